// *** msc_pkg.sv ***
// package for the miscellaneous system-control block
`default_nettype none
package msc_pkg;
    // register byte offsets
    localparam logic [3:0] ROM_SETUP_OFS = 4'h0;
    localparam logic [3:0] SPEED_STATUS_OFS = 4'h4;
    localparam logic [3:0] STRAP_STATUS_OFS = 4'h8;
    localparam logic [3:0] SPEAKER_CTRL_OFS = 4'hc;
    // field positions
    localparam int FLASH_PROGRAM_BIT = 2;
    localparam int FULL_SPEED_BIT = 0;
    localparam int SLEEP_BIT = 1;
    localparam int SPEAKER_BIT = 0;
    localparam int STRAP_MISS_BIT = 0;
    localparam int STRAP_SLOT_BIT = 1;
    localparam int STRAP_DRAMDRV_BIT = 2;
    localparam int STRAP_DRAMCFG_BIT = 3;
    localparam int STRAP_FLOAT_BIT = 4;
    // reset values
    localparam logic [7:0] ROM_SETUP_RST = 8'h00;
    localparam logic [4:0] STRAP_RST = 5'h1f;
    // peripheral select decode addresses
    localparam logic [15:0] KBD_DATA_ADDR = 16'h0060;
    localparam logic [15:0] KBD_CMD_ADDR = 16'h0064;
    localparam logic [15:0] RTC_INDEX_ADDR = 16'h0070;
    localparam logic [15:0] RTC_DATA_ADDR = 16'h0071;
    // hold pacing for slow mode: cycles of hold per period
    localparam logic [3:0] SLOW_PERIOD = 4'hf;
    localparam logic [3:0] SLOW_HOLD_CYCLES = 4'h8;

    typedef enum logic [1:0] {
        ST_POR = 2'b00,
        ST_RUN = 2'b01,
        ST_SLEEP = 2'b11
    } msc_state_t;

    typedef struct packed {
        logic float_n;
        logic dram_cfg;
        logic dram_drv;
        logic slot_drv;
        logic miss_mode_n;
    } msc_strap_t;
endpackage
`default_nettype wire

// *** msc_top.sv ***
// miscellaneous system control: flash strobe, selects, sleep, turbo, speaker and straps
// How it works
// - flash bit two drives flash strobe low
// - claim by T2 end deselects this device
// - rom select low on system rom access
// - power stable low means power-on reset
// - float pin sampled low floats all outputs
// - afterwards pin drives active-high speaker
// - falling sleep request enters sleep mode
// - sleep: refresh on, oscillator gated, hold high
// - full-speed low generates repeated hold requests
// - full-speed level readable in status register
// - latch-enable pin strap selects miss mode
// - flash pin strap selects slot drive
// - peripheral select strap selects DRAM drive
// - rom select strap selects DRAM configuration
// - write-back strap: miss high inhibits reads
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
module msc_top #(
    parameter logic [19:0] ROM_BASE = 20'he0000,
    parameter logic [19:0] ROM_LIMIT = 20'hfffff
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    // avalon-mm slave
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // cpu cycle view
    input wire logic [19:0] CPU_ADDR_I,
    input wire logic CPU_MEM_I,
    input wire logic CPU_CYCLE_I,
    input wire logic CPU_T2_END_I,
    input wire logic [15:0] SYS_ADDR_I,
    input wire logic SYS_IO_I,
    input wire logic LOCAL_BUS_CLAIM_N_I,
    output logic DESELECT_O,
    // power and modes
    input wire logic POWER_STABLE_I,
    input wire logic SLEEP_REQ_N_I,
    input wire logic FULL_SPEED_I,
    output logic HOLD_O,
    output logic REFRESH_EN_O,
    output logic BUS_OSC_GATE_O,
    output logic FLOAT_ALL_O,
    // write-back cache qualification
    input wire logic CACHE_MISS_N_I,
    input wire logic MEMORY_READ_CMD_N_I,
    input wire logic DMA_DRAM_READ_I,
    output logic DRAM_READ_INHIBIT_O,
    // shared pins: input, output, output enable; the latch-enable pin has no output
    input wire logic SPEAKER_OR_FLOAT_N_I,
    output logic SPEAKER_OR_FLOAT_N_O,
    output logic SPEAKER_OR_FLOAT_N_OE_O,
    input wire logic EARLY_LATCH_ENABLE_N_I,
    output logic EARLY_LATCH_ENABLE_N_OE_O,
    input wire logic FLASH_PROGRAM_OUT_N_I,
    output logic FLASH_PROGRAM_OUT_N_O,
    output logic FLASH_PROGRAM_OUT_N_OE_O,
    input wire logic PERIPHERAL_SELECT_N_I,
    output logic PERIPHERAL_SELECT_N_O,
    output logic PERIPHERAL_SELECT_N_OE_O,
    input wire logic ROM_SELECT_N_I,
    output logic ROM_SELECT_N_O,
    output logic ROM_SELECT_N_OE_O,
    // strap results
    output logic [4:0] STRAP_O
);

    function automatic logic periph_hit(input logic [15:0] a);
        periph_hit = (a == msc_pkg::KBD_DATA_ADDR) || (a == msc_pkg::KBD_CMD_ADDR) ||
                     (a == msc_pkg::RTC_INDEX_ADDR) || (a == msc_pkg::RTC_DATA_ADDR);
    endfunction

    msc_pkg::msc_state_t state_r;
    msc_pkg::msc_state_t state_nxt;
    msc_pkg::msc_strap_t strap_r;
    logic [7:0] rom_setup_r;
    logic speaker_r;
    logic stable_d_r;
    logic sleep_d_r;
    logic full_speed_r;
    logic [3:0] slow_cnt_r;
    logic claimed_r;
    logic rd_pending_r;
    logic [31:0] rdata_nxt;
    logic wr_lo;
    logic por_active;
    logic drive_en;

    assign por_active = !POWER_STABLE_I;
    assign wr_lo = AVS_WRITE_I && AVS_BYTEENABLE_I[0];
    // outputs float when the strap asked for it, and shared pins stay inputs during power-on
    assign drive_en = !por_active && strap_r.float_n;

    // power-on / run / sleep sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            msc_pkg::ST_POR: begin
                if (POWER_STABLE_I) begin
                    state_nxt = msc_pkg::ST_RUN;
                end
            end
            msc_pkg::ST_RUN: begin
                if (sleep_d_r && !SLEEP_REQ_N_I) begin
                    state_nxt = msc_pkg::ST_SLEEP;
                end
            end
            msc_pkg::ST_SLEEP: begin
                // sleep is left only by power-on reset; software sees it in the status word
                state_nxt = msc_pkg::ST_SLEEP;
            end
            default: begin
                // the unused code falls back to power-on rather than locking up
                state_nxt = msc_pkg::ST_POR;
            end
        endcase
        if (por_active) begin
            state_nxt = msc_pkg::ST_POR;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_r <= msc_pkg::ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            stable_d_r <= 1'b0;
            sleep_d_r <= 1'b1;
            full_speed_r <= 1'b1;
        end else begin
            stable_d_r <= POWER_STABLE_I;
            sleep_d_r <= SLEEP_REQ_N_I;
            full_speed_r <= FULL_SPEED_I;
        end
    end

    // straps follow the pins through power-on and freeze at the rising edge of power stable
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            strap_r <= msc_pkg::STRAP_RST;
        end else if (por_active) begin
            strap_r.miss_mode_n <= EARLY_LATCH_ENABLE_N_I;
            strap_r.slot_drv <= FLASH_PROGRAM_OUT_N_I;
            strap_r.dram_drv <= PERIPHERAL_SELECT_N_I;
            strap_r.dram_cfg <= ROM_SELECT_N_I;
            strap_r.float_n <= SPEAKER_OR_FLOAT_N_I;
        end
    end
    // with no else branch above, the straps hold their value once power stable is high

    // register file
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rom_setup_r <= msc_pkg::ROM_SETUP_RST;
            speaker_r <= 1'b0;
        end else if (por_active) begin
            rom_setup_r <= msc_pkg::ROM_SETUP_RST;
            speaker_r <= 1'b0;
        end else if (wr_lo && !AVS_WAITREQUEST_O) begin
            if (AVS_ADDRESS_I == msc_pkg::ROM_SETUP_OFS) begin
                rom_setup_r <= AVS_WRITEDATA_I[7:0];
            end
            if (AVS_ADDRESS_I == msc_pkg::SPEAKER_CTRL_OFS) begin
                speaker_r <= AVS_WRITEDATA_I[msc_pkg::SPEAKER_BIT];
            end
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (AVS_ADDRESS_I)
            msc_pkg::ROM_SETUP_OFS: rdata_nxt[7:0] = rom_setup_r;
            msc_pkg::SPEED_STATUS_OFS: begin
                rdata_nxt[msc_pkg::FULL_SPEED_BIT] = full_speed_r;
                rdata_nxt[msc_pkg::SLEEP_BIT] = (state_r == msc_pkg::ST_SLEEP);
            end
            msc_pkg::STRAP_STATUS_OFS: rdata_nxt[4:0] = strap_r;
            msc_pkg::SPEAKER_CTRL_OFS: rdata_nxt[msc_pkg::SPEAKER_BIT] = speaker_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // reads take one wait cycle so read data comes from a flop; writes are taken at once
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_pending_r <= 1'b0;
            AVS_READDATA_O <= 32'h0000_0000;
        end else begin
            rd_pending_r <= AVS_READ_I && !rd_pending_r;
            if (AVS_READ_I && !rd_pending_r) begin
                AVS_READDATA_O <= rdata_nxt;
            end
        end
    end

    always_comb begin
        AVS_WAITREQUEST_O = AVS_READ_I && !rd_pending_r;
    end

    // slow-mode hold pacing
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            slow_cnt_r <= 4'h0;
        end else if (slow_cnt_r == msc_pkg::SLOW_PERIOD) begin
            slow_cnt_r <= 4'h0;
        end else begin
            slow_cnt_r <= slow_cnt_r + 4'h1;
        end
    end

    // deselect for the rest of a cycle once the claim is seen by the end of the first T2
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            claimed_r <= 1'b0;
        end else if (!CPU_CYCLE_I) begin
            claimed_r <= 1'b0;
        end else if (CPU_T2_END_I && !LOCAL_BUS_CLAIM_N_I) begin
            claimed_r <= 1'b1;
        end
    end

    // deselect: the claim at the end of the first T2 takes effect on the next edge
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            DESELECT_O <= 1'b0;
        end else begin
            DESELECT_O <= CPU_CYCLE_I && (claimed_r || (CPU_T2_END_I && !LOCAL_BUS_CLAIM_N_I));
        end
    end

    // hold, refresh and oscillator gating
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            HOLD_O <= 1'b0;
            REFRESH_EN_O <= 1'b1;
            BUS_OSC_GATE_O <= 1'b1;
        end else begin
            HOLD_O <= (state_r == msc_pkg::ST_SLEEP) ||
                      (!full_speed_r && (slow_cnt_r < msc_pkg::SLOW_HOLD_CYCLES));
            // refresh never stops, so memory contents survive sleep
            REFRESH_EN_O <= 1'b1;
            BUS_OSC_GATE_O <= (state_r != msc_pkg::ST_SLEEP);
        end
    end

    // float indication and write-back read inhibit
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            FLOAT_ALL_O <= 1'b0;
            DRAM_READ_INHIBIT_O <= 1'b0;
        end else begin
            FLOAT_ALL_O <= !strap_r.float_n && !por_active;
            DRAM_READ_INHIBIT_O <= !strap_r.miss_mode_n && CACHE_MISS_N_I &&
                                   !MEMORY_READ_CMD_N_I && DMA_DRAM_READ_I;
        end
    end

    // speaker and latch-enable pin enables
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SPEAKER_OR_FLOAT_N_O <= 1'b0;
            SPEAKER_OR_FLOAT_N_OE_O <= 1'b0;
            EARLY_LATCH_ENABLE_N_OE_O <= 1'b0;
        end else begin
            SPEAKER_OR_FLOAT_N_O <= speaker_r;
            SPEAKER_OR_FLOAT_N_OE_O <= drive_en;
            EARLY_LATCH_ENABLE_N_OE_O <= drive_en;
        end
    end

    // flash programming strobe
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            FLASH_PROGRAM_OUT_N_O <= 1'b1;
            FLASH_PROGRAM_OUT_N_OE_O <= 1'b0;
        end else begin
            FLASH_PROGRAM_OUT_N_O <= !rom_setup_r[msc_pkg::FLASH_PROGRAM_BIT];
            FLASH_PROGRAM_OUT_N_OE_O <= drive_en;
        end
    end

    // peripheral select: decoded on the four keyboard and clock io addresses only, one cycle late
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PERIPHERAL_SELECT_N_O <= 1'b1;
            PERIPHERAL_SELECT_N_OE_O <= 1'b0;
        end else begin
            PERIPHERAL_SELECT_N_O <= !(SYS_IO_I && periph_hit(SYS_ADDR_I));
            PERIPHERAL_SELECT_N_OE_O <= drive_en;
        end
    end

    // rom select: a claimed cycle belongs to the local device, so the rom select goes high the edge after claimed_r is set
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ROM_SELECT_N_O <= 1'b1;
            ROM_SELECT_N_OE_O <= 1'b0;
        end else begin
            ROM_SELECT_N_O <= !(CPU_CYCLE_I && CPU_MEM_I && !claimed_r &&
                                CPU_ADDR_I >= ROM_BASE && CPU_ADDR_I <= ROM_LIMIT);
            ROM_SELECT_N_OE_O <= drive_en;
        end
    end

    // strap copy for the rest of the chip
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            STRAP_O <= msc_pkg::STRAP_RST;
        end else begin
            STRAP_O <= strap_r;
        end
    end

endmodule // msc_top
`default_nettype wire

// *** msc_checker.sv ***
// port-level checks for the system-control block
`default_nettype none
module msc_checker (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [15:0] SYS_ADDR_I,
    input wire logic SYS_IO_I,
    input wire logic PERIPHERAL_SELECT_N_O,
    input wire logic CPU_CYCLE_I,
    input wire logic CPU_T2_END_I,
    input wire logic LOCAL_BUS_CLAIM_N_I,
    input wire logic DESELECT_O,
    input wire logic POWER_STABLE_I,
    input wire logic SPEAKER_OR_FLOAT_N_OE_O,
    input wire logic ROM_SELECT_N_OE_O,
    input wire logic [4:0] STRAP_O,
    input wire logic FLOAT_ALL_O,
    input wire logic SLEEP_REQ_N_I,
    input wire logic FULL_SPEED_I,
    input wire logic HOLD_O,
    input wire logic BUS_OSC_GATE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wire logic kbd = SYS_IO_I && (SYS_ADDR_I inside {16'h0060, 16'h0064, 16'h0070, 16'h0071});
    a_kbd_select: assert property (##1 PERIPHERAL_SELECT_N_O == !$past(kbd)) else $error("select decode");
    a_claim_deselect: assert property (CPU_CYCLE_I && CPU_T2_END_I && !LOCAL_BUS_CLAIM_N_I |=> DESELECT_O)
        else $error("claim ignored");
    a_power_float: assert property (!POWER_STABLE_I [*2] |-> !SPEAKER_OR_FLOAT_N_OE_O && !ROM_SELECT_N_OE_O)
        else $error("pin driven at power-on");
    a_strap_frozen: assert property (POWER_STABLE_I [*2] |=> $stable(STRAP_O)) else $error("strap moved");
    a_float_all: assert property (POWER_STABLE_I [*3] |-> FLOAT_ALL_O == !STRAP_O[4]) else $error("float");
    a_sleep_entry: assert property (POWER_STABLE_I && $fell(SLEEP_REQ_N_I) |-> ##[1:2] (HOLD_O && !BUS_OSC_GATE_O))
        else $error("no sleep");
    a_sleep_stays: assert property (HOLD_O && !BUS_OSC_GATE_O && POWER_STABLE_I |=> HOLD_O) else $error("woke");
    a_slow_hold: assert property (!FULL_SPEED_I [*3] |-> ##[0:16] (HOLD_O || FULL_SPEED_I)) else $error("no hold");
    c_claim: cover property (CPU_T2_END_I && !LOCAL_BUS_CLAIM_N_I);
    c_sleep: cover property ($fell(SLEEP_REQ_N_I));
    c_float: cover property (FLOAT_ALL_O);
endmodule // msc_checker
bind msc_top msc_checker i_chk (.*);
`default_nettype wire

// *** msc_partner.sv ***
// far side: a local bus device and the board strap resistors
`default_nettype none
module msc_partner (
    input wire logic cyc_i,
    input wire logic claim_i,
    input wire logic [4:0] strap_i,
    input wire logic [4:0] oe_i,
    input wire logic [4:0] out_i,
    output logic claim_n_o,
    output logic [4:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // claims at once, well before the first T2 ends, and lets go with the cycle
    assign claim_n_o = !(cyc_i && claim_i);
    // a released pin falls to its resistor, not to the last driven level
    assign pin_o = (oe_i & out_i) | (~oe_i & strap_i);
endmodule // msc_partner
`default_nettype wire

// *** test_misc_system_control_pins.sv ***
// self-checking bench for the system-control block
`default_nettype none
module test_misc_system_control_pins;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [31:0] v; logic [31:0] m;} msc_exp_t;
    localparam logic [15:0] KA [6] = '{16'h0060, 16'h0064, 16'h0070, 16'h0071, 16'h0061, 16'h0170};
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, mem = 1'b0, cyc = 1'b0, t2 = 1'b0, sio = 1'b0;
    logic pwr = 1'b0, slp_n = 1'b1, fast = 1'b1, memory_read_cmd_n_n = 1'b1, dma = 1'b0, clm = 1'b0, look = 1'b0;
    logic miss_n = 1'b1;
    logic [3:0] adr = 4'h0, be = 4'hf;
    logic [31:0] wd = 32'h0;
    logic [19:0] ca = 20'h0;
    logic [15:0] sa = 16'h0;
    logic [4:0] strap = 5'h1f;
    wire logic [31:0] rdd;
    wire logic wt, clm_n, desel, hold, gate, flt, inh;
    wire logic [4:0] oe, po, pin, so;
    // pins in one word so one queue serves reads and pin looks
    wire logic [31:0] obs = {18'h0, pin[4], inh, so, flt, gate, hold, desel, po[3:1]};
    msc_exp_t q[$];
    int miscompares = 0;
    int total_checks = 0;
    int n;
    always #2 clk = ~clk;
    assign po[0] = 1'b0;
    msc_top i_dut (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdd), .AVS_WAITREQUEST_O(wt),
        .CPU_ADDR_I(ca), .CPU_MEM_I(mem), .CPU_CYCLE_I(cyc), .CPU_T2_END_I(t2), .SYS_ADDR_I(sa),
        .SYS_IO_I(sio), .LOCAL_BUS_CLAIM_N_I(clm_n), .DESELECT_O(desel), .POWER_STABLE_I(pwr),
        .SLEEP_REQ_N_I(slp_n), .FULL_SPEED_I(fast), .HOLD_O(hold), .REFRESH_EN_O(), .BUS_OSC_GATE_O(gate),
        .FLOAT_ALL_O(flt), .CACHE_MISS_N_I(miss_n), .MEMORY_READ_CMD_N_I(memory_read_cmd_n_n), .DMA_DRAM_READ_I(dma),
        .DRAM_READ_INHIBIT_O(inh), .SPEAKER_OR_FLOAT_N_I(pin[4]), .SPEAKER_OR_FLOAT_N_O(po[4]),
        .SPEAKER_OR_FLOAT_N_OE_O(oe[4]), .EARLY_LATCH_ENABLE_N_I(pin[0]), .EARLY_LATCH_ENABLE_N_OE_O(oe[0]),
        .FLASH_PROGRAM_OUT_N_I(pin[1]), .FLASH_PROGRAM_OUT_N_O(po[1]), .FLASH_PROGRAM_OUT_N_OE_O(oe[1]),
        .PERIPHERAL_SELECT_N_I(pin[2]), .PERIPHERAL_SELECT_N_O(po[2]), .PERIPHERAL_SELECT_N_OE_O(oe[2]),
        .ROM_SELECT_N_I(pin[3]), .ROM_SELECT_N_O(po[3]), .ROM_SELECT_N_OE_O(oe[3]), .STRAP_O(so));
    msc_partner i_far (.cyc_i(cyc), .claim_i(clm), .strap_i(strap), .oe_i(oe), .out_i(po),
        .claim_n_o(clm_n), .pin_o(pin));
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input msc_exp_t e);
        total_checks++;
        if ((seen & e.m) !== (e.v & e.m)) begin
            miscompares++;
            $display("Error %s expected %h seen %h", look ? "pins" : "readdata", e.v & e.m, seen & e.m);
        end
    endtask
    always @(posedge clk) begin
        if ((rd && !wt) || look)
            check(look ? obs : rdd, q.pop_front());
    end
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int k = 0;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk); while (wt !== 1'b0 && ++k < 40);
        if (wt !== 1'b0) begin
            miscompares++;
            end_of_test();
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdx(input logic [3:0] a, input logic [31:0] v);
        q.push_back('{v, 32'hffffffff});
        bus(a, 1'b0, 32'h0);
    endtask
    // registered pins settle within two edges, then one edge is looked at
    task automatic peek(input logic [31:0] v, input logic [31:0] m);
        repeat (2) @(posedge clk);
        q.push_back('{v, m});
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask
    initial begin
        n = $urandom(78);
        strap = {1'b1, 4'($urandom())};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        pwr <= 1'b1;
        peek({20'h0, strap, 7'h0}, 32'h2f80);
        rdx(msc_pkg::STRAP_STATUS_OFS, {27'h0, strap});
        rdx(4'h2, 32'h0);
        bus(msc_pkg::ROM_SETUP_OFS, 1'b1, 32'h4);
        peek(32'h0, 32'h1);
        rdx(msc_pkg::ROM_SETUP_OFS, 32'h4);
        be <= 4'he;
        bus(msc_pkg::ROM_SETUP_OFS, 1'b1, 32'h0);
        be <= 4'hf;
        peek(32'h0, 32'h1);
        bus(msc_pkg::ROM_SETUP_OFS, 1'b1, 32'h0);
        peek(32'h1, 32'h1);
        bus(msc_pkg::SPEAKER_CTRL_OFS, 1'b1, 32'h1);
        peek(32'h2000, 32'h2000);
        sio <= 1'b1;
        for (n = 0; n < 6; n++) begin
            sa <= KA[n];
            peek({30'h0, n > 3, 1'b0}, 32'h2);
        end
        sio <= 1'b0;
        cyc <= 1'b1;
        mem <= 1'b1;
        ca <= {3'h7, 17'($urandom())};
        peek(32'h0, 32'h4);
        cyc <= 1'b0;
        @(posedge clk);
        cyc <= 1'b1;
        ca <= 20'h12340;
        clm <= 1'b1;
        peek(32'h4, 32'h4);
        t2 <= 1'b1;
        @(posedge clk);
        t2 <= 1'b0;
        peek(32'h8, 32'h8);
        cyc <= 1'b0;
        clm <= 1'b0;
        fast <= 1'b0;
        repeat (2) @(posedge clk);
        rdx(msc_pkg::SPEED_STATUS_OFS, 32'h0);
        for (n = 0; n < 40 && hold !== 1'b0; n++) @(posedge clk);
        if (hold !== 1'b0) miscompares++;
        for (n = 0; n < 40 && hold !== 1'b1; n++) @(posedge clk);
        if (hold !== 1'b1) miscompares++;
        peek(32'h10, 32'h10);
        fast <= 1'b1;
        repeat (2) @(posedge clk);
        rdx(msc_pkg::SPEED_STATUS_OFS, 32'h1);
        dma <= 1'b1;
        memory_read_cmd_n_n <= 1'b0;
        peek({19'h0, !strap[0], 12'h0}, 32'h1000);
        miss_n <= 1'b0;
        peek(32'h0, 32'h1000);
        miss_n <= 1'b1;
        slp_n <= 1'b0;
        peek(32'h10, 32'h30);
        pwr <= 1'b0;
        strap[4] <= 1'b0;
        repeat (3) @(posedge clk);
        pwr <= 1'b1;
        peek(32'h40, 32'h40);
        end_of_test();
    end
endmodule // test_misc_system_control_pins
`default_nettype wire
